// ### prcg_pkg.sv
// Constants shared by both ends of the peripheral reset and clock gate.
// Assumes one bus clock and one synchronous active-low reset everywhere.
package prcg_pkg;

  // Register index on the link between the two ends
  localparam logic IDX_RESET_CTRL_0 = 1'h0;
  localparam logic IDX_CLOCK_ENABLE_1 = 1'h1;

  // Field positions in peripheral_reset_ctrl_0
  localparam int EXT_BUS_RESET_POS = 26;
  localparam int DMA_RESET_POS = 24;
  localparam int CONVERTER_RESET_LSB = 16;
  localparam int SERIAL_RESET_LSB = 0;

  // Field position in peripheral_clock_enable_1
  localparam int QUAD_CLOCK_EN_LSB = 16;

  // Writable bits; every other bit is reserved and reads as zero
  localparam logic [31:0] RESET_CTRL_0_WMASK = 32'h050F_FFFF;
  localparam logic [31:0] CLOCK_ENABLE_1_WMASK = 32'h000F_0000;

  // Values after reset
  localparam logic [31:0] RESET_CTRL_0_INIT = 32'h0000_0000;
  localparam logic [31:0] CLOCK_ENABLE_1_INIT = 32'h000F_0000;
  localparam logic EXT_BUS_RESET_INIT = 1'h0;
  localparam logic DMA_RESET_INIT = 1'h0;
  localparam logic [3:0] CONVERTER_RESET_INIT = 4'h0;
  localparam logic [15:0] SERIAL_RESET_INIT = 16'h0000;
  localparam logic [3:0] QUAD_CLOCK_EN_INIT = 4'hF;

  // Wishbone byte offsets of the controller's own registers
  localparam logic [3:0] WB_OFF_RESET_CTRL_0 = 4'h0;
  localparam logic [3:0] WB_OFF_CLOCK_ENABLE_1 = 4'h4;
  localparam logic [31:0] WB_UNMAPPED_DATA = 32'h0000_0000;

  // Controller states
  typedef enum logic [1:0] {
    PRCG_IDLE,
    PRCG_LINK,
    PRCG_DONE
  } prcg_state_t;

endpackage

// ### prcg_if.sv
// Link between the register controller and the reset/clock-gate end.
// Assumes both ends run on the same bus clock; no clocking block.
`timescale 1ns/100ps
interface prcg_if;
  logic link_req;
  logic link_we;
  logic link_idx;
  logic [31:0] link_wdata;
  logic [31:0] link_rdata;
  logic link_ack;

  // Reset/clock-gate end
  modport dev (
    input link_req,
    input link_we,
    input link_idx,
    input link_wdata,
    output link_rdata,
    output link_ack
  );

  // Register controller end
  modport host (
    output link_req,
    output link_we,
    output link_idx,
    output link_wdata,
    input link_rdata,
    input link_ack
  );
endinterface

// ### prcg_dev.sv
// Reset and bus-clock gate end: holds the reset register and the
// quad-counter clock enables, and drives one level line per peripheral.
// Assumes the controller holds each request until it sees link_ack.
//
// Function
// - Software writes zero to every reserved bit.
// - External-bus bit one holds interface in reset.
// - External-bus reset released only by writing zero.
// - Without external bus, leave its bit alone.
// - Pulse external-bus reset before programming its registers.
// - External-bus reset keeps that interface's registers.
// - DMA bit one stops transfers, clears settings.
// - Bits 16..19 reset converter units 0..3.
// - Converter reset stops conversion until bit cleared.
// - Missing converter unit: leave its bit alone.
// - Bits 15..0 reset serial channels 15..0.
// - Serial reset halts channel until bit cleared.
// - Never set reset of absent serial channel.
// - All reset bits come up zero.
// - Clock bits 16..19 gate quad-counter units 0..3.
// - Clock bit zero stops that unit's clock.
// - Quad-counter clock bits come up one.
// - Missing quad-counter unit: leave its bit alone.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module prcg_dev
  import prcg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  prcg_if.dev link,
  output logic ext_bus_logic_rst,
  output logic dma_rst,
  output logic [3:0] converter_rst,
  output logic [15:0] serial_rst,
  output logic [3:0] quad_clock_en,
  output logic periph_rst_any
);

  // Merge write data into a stored value under a writable mask.
  // Shared by both registers so the reserved-bit policy sits in one place.
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [31:0] wmask
  );
    merge_write = (old_val & ~wmask) | (new_val & wmask);
  endfunction

  // Stored fields, one flop per peripheral line.
  // Kept as separate fields, not one word, so each line is plainly
  // a flop output with its own reset value.
  logic ext_bus_rst_ff;
  logic dma_rst_ff;
  logic [3:0] converter_rst_ff;
  logic [15:0] serial_rst_ff;
  logic [3:0] quad_clock_en_ff;
  logic rst_any_ff;

  // Link answer flops
  logic ack_ff;
  logic [31:0] rdata_ff;

  // Next values
  logic nxt_ack;
  logic [31:0] nxt_rdata;
  logic [31:0] nxt_reset_word;
  logic [31:0] nxt_clock_word;
  logic nxt_rst_any;

  // Current register images, reserved bits zero
  wire logic [31:0] reset_word;
  wire logic [31:0] clock_word;

  assign reset_word = {5'h00,
                       ext_bus_rst_ff,
                       1'h0,
                       dma_rst_ff,
                       4'h0,
                       converter_rst_ff,
                       serial_rst_ff};
  assign clock_word = {12'h000, quad_clock_en_ff, 16'h0000};

  // Request decode; one answer per held request.
  // The ack flop masks the request in the ack cycle, because the
  // controller only drops req once it has seen ack.
  wire logic take_req;
  wire logic take_write;
  wire logic wr_reset;
  wire logic wr_clock;

  assign take_req = link.link_req & ~ack_ff;
  assign take_write = take_req & link.link_we;
  assign wr_reset = take_write & (link.link_idx == IDX_RESET_CTRL_0);
  assign wr_clock = take_write & (link.link_idx == IDX_CLOCK_ENABLE_1);

  // Reserved bits are dropped here so they always read zero
  assign nxt_reset_word = wr_reset ?
    merge_write(reset_word, link.link_wdata, RESET_CTRL_0_WMASK) :
    reset_word;
  assign nxt_clock_word = wr_clock ?
    merge_write(clock_word, link.link_wdata, CLOCK_ENABLE_1_WMASK) :
    clock_word;

  // Ack falls in the cycle after it rose, even if req is still high
  assign nxt_ack = take_req;

  // Read answer shows the register image after any write in this cycle.
  // A plain read returns the stored image unchanged.
  assign nxt_rdata = !take_req ? rdata_ff :
                     (link.link_idx == IDX_RESET_CTRL_0) ? nxt_reset_word :
                     nxt_clock_word;

  // Summary line, handy for a reset monitor.
  // Built from the next image so it moves with the lines, not after them.
  assign nxt_rst_any = |(nxt_reset_word & RESET_CTRL_0_WMASK);

  // Link answer registers
  // Read data holds between answers; only ack is a pulse.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_ff <= 1'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // External bus: logic-only reset, held until software writes zero.
  // No automatic release: the bit stays until a write clears it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_bus_rst_ff <= EXT_BUS_RESET_INIT;
    end else begin
      ext_bus_rst_ff <= nxt_reset_word[EXT_BUS_RESET_POS];
    end
  end

  // DMA controller reset
  // Held while the bit is one; its transfers stay stopped meanwhile.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_rst_ff <= DMA_RESET_INIT;
    end else begin
      dma_rst_ff <= nxt_reset_word[DMA_RESET_POS];
    end
  end

  // Converter unit resets, unit n at bit 16+n
  // Absent units are kept at their initial value by the controller end.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      converter_rst_ff <= CONVERTER_RESET_INIT;
    end else begin
      converter_rst_ff <=
        nxt_reset_word[CONVERTER_RESET_LSB +: 4];
    end
  end

  // Serial channel resets, channel n at bit n
  // A set bit for an absent channel is refused upstream, not here.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      serial_rst_ff <= SERIAL_RESET_INIT;
    end else begin
      serial_rst_ff <= nxt_reset_word[SERIAL_RESET_LSB +: 16];
    end
  end

  // Quad-counter clock enables; supplied after reset
  // A one is the running state, so the counters tick straight away.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      quad_clock_en_ff <= QUAD_CLOCK_EN_INIT;
    end else begin
      quad_clock_en_ff <= nxt_clock_word[QUAD_CLOCK_EN_LSB +: 4];
    end
  end

  // Any reset line active
  // Covers the reset register only; clock gating is not a reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rst_any_ff <= 1'h0;
    end else begin
      rst_any_ff <= nxt_rst_any;
    end
  end

  // Link outputs
  assign link.link_ack = ack_ff;
  assign link.link_rdata = rdata_ff;

  // Peripheral lines come straight from the flops, as levels.
  // The external-bus line is meant for that interface's sequencing
  // logic only; it must not reach its register file, so settings
  // survive the reset. The DMA, converter and serial lines clear
  // their blocks' registers as well as stopping them.
  assign ext_bus_logic_rst = ext_bus_rst_ff;
  assign dma_rst = dma_rst_ff;
  assign converter_rst = converter_rst_ff;
  assign serial_rst = serial_rst_ff;

  // Enable for an integrated clock gate at each counter unit.
  // A zero stops that unit's bus clock; gating is left to a glitch-free
  // cell next to the unit rather than done in fabric here.
  assign quad_clock_en = quad_clock_en_ff;

  // Summary output, changes in the same cycle as the lines
  assign periph_rst_any = rst_any_ff;

endmodule

// ### prcg_host.sv
// Register controller end: a classic Wishbone slave that forwards each mapped
// access to the reset/clock-gate end over the link and waits for it.
// Assumes the Wishbone master holds its request until it sees ack.
`timescale 1ns/100ps
module prcg_host
  import prcg_pkg::*;
#(
  parameter logic EXT_BUS_PRESENT = 1'h1,
  parameter logic [3:0] CONVERTER_PRESENT = 4'hF,
  parameter logic [15:0] SERIAL_PRESENT = 16'hFFFF,
  parameter logic [3:0] QUAD_PRESENT = 4'hF
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  prcg_if.host link
);

  // Bits that may change: writable and belonging to a mounted unit.
  // The DMA controller is always mounted.
  localparam logic [31:0] RESET_MOUNTED = {5'h00, EXT_BUS_PRESENT, 1'h0,
    1'h1, 4'h0, CONVERTER_PRESENT, SERIAL_PRESENT};
  localparam logic [31:0] CLOCK_MOUNTED = {12'h000, QUAD_PRESENT, 16'h0000};

  // Absent units keep their initial value; reserved bits go out as zero
  function automatic logic [31:0] guard_write(
    input logic [31:0] data,
    input logic [31:0] mounted,
    input logic [31:0] init,
    input logic [31:0] wmask
  );
    guard_write = ((data & mounted) | (init & ~mounted)) & wmask;
  endfunction

  prcg_state_t state_ff, nxt_state;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic req_ff, nxt_req;
  logic we_ff, nxt_we;
  logic idx_ff, nxt_idx;
  logic [31:0] wdata_ff, nxt_wdata;

  // Wishbone decode; sel picks byte lanes, unselected lanes reuse the last link word
  wire logic wb_req;
  wire logic hit_reset;
  wire logic hit_clock;
  wire logic [31:0] sel_mask;
  wire logic [31:0] wr_guarded;

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign hit_reset = (wb_adr_i == WB_OFF_RESET_CTRL_0);
  assign hit_clock = (wb_adr_i == WB_OFF_CLOCK_ENABLE_1);
  assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Lanes not selected keep the last written value of the controller
  assign wr_guarded = hit_reset ?
    guard_write((wb_dat_i & sel_mask) | (wdata_ff & ~sel_mask),
                RESET_MOUNTED, RESET_CTRL_0_INIT,
                RESET_CTRL_0_WMASK) :
    guard_write((wb_dat_i & sel_mask) | (wdata_ff & ~sel_mask),
                CLOCK_MOUNTED, CLOCK_ENABLE_1_INIT,
                CLOCK_ENABLE_1_WMASK);

  // Controller sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_ack = 1'h0;
    nxt_dat = dat_ff;
    nxt_req = req_ff;
    nxt_we = we_ff;
    nxt_idx = idx_ff;
    nxt_wdata = wdata_ff;
    unique case (state_ff)
      PRCG_IDLE: begin
        if (wb_req && (hit_reset || hit_clock)) begin
          nxt_req = 1'h1;
          nxt_we = wb_we_i;
          nxt_idx = hit_reset ? IDX_RESET_CTRL_0 : IDX_CLOCK_ENABLE_1;
          nxt_wdata = wb_we_i ? wr_guarded : wdata_ff;
          nxt_state = PRCG_LINK;
        end else if (wb_req) begin
          // Unmapped: answer at once, write dropped, read zero
          nxt_ack = 1'h1;
          nxt_dat = WB_UNMAPPED_DATA;
          nxt_state = PRCG_DONE;
        end
      end
      PRCG_LINK: begin
        if (link.link_ack) begin
          nxt_req = 1'h0;
          nxt_ack = 1'h1;
          nxt_dat = link.link_rdata;
          nxt_state = PRCG_DONE;
        end
      end
      PRCG_DONE: begin
        // One idle cycle lets the master drop cyc before the next access
        nxt_state = PRCG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= PRCG_IDLE;
      ack_ff <= 1'h0;
      dat_ff <= 32'h0000_0000;
      req_ff <= 1'h0;
      we_ff <= 1'h0;
      idx_ff <= 1'h0;
      wdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      req_ff <= nxt_req;
      we_ff <= nxt_we;
      idx_ff <= nxt_idx;
      wdata_ff <= nxt_wdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign link.link_req = req_ff;
  assign link.link_we = we_ff;
  assign link.link_idx = idx_ff;
  assign link.link_wdata = wdata_ff;

endmodule

// ### prcg_checker.sv
// Checker for the link between the two ends and the peripheral lines.
// Assumes one bus clock; placed beside the link interface.
`timescale 1ns/100ps
module prcg_checker
  import prcg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_req,
  input wire logic link_we,
  input wire logic link_idx,
  input wire logic [31:0] link_wdata,
  input wire logic link_ack,
  input wire logic ext_bus_logic_rst,
  input wire logic dma_rst,
  input wire logic [3:0] converter_rst,
  input wire logic [15:0] serial_rst,
  input wire logic [3:0] quad_clock_en,
  input wire logic periph_rst_any
);
  // Write taken at this edge; reset lines gathered as one word
  wire logic wr_take;
  wire logic [21:0] rst_lines;
  assign wr_take = link_req && !link_ack && link_we;
  assign rst_lines = {ext_bus_logic_rst, dma_rst, converter_rst, serial_rst};

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_EXT_BUS_LEVEL: assert property (wr_take && !link_idx |=>
    ext_bus_logic_rst == $past(link_wdata[26]))
    else $error("ext bus reset line wrong");
  AST_DMA_LEVEL: assert property (wr_take && !link_idx |=>
    dma_rst == $past(link_wdata[24]))
    else $error("dma reset line wrong");
  AST_CONVERTER_MAP: assert property (wr_take && !link_idx |=>
    converter_rst == $past(link_wdata[19:16]))
    else $error("converter reset lines wrong");
  AST_SERIAL_MAP: assert property (wr_take && !link_idx |=>
    serial_rst == $past(link_wdata[15:0]))
    else $error("serial reset lines wrong");
  AST_QUAD_GATE: assert property (wr_take && link_idx |=>
    quad_clock_en == $past(link_wdata[19:16]))
    else $error("quad clock enables wrong");
  // Lines are levels: nothing moves without a write
  AST_LINES_HOLD: assert property (!wr_take |=>
    $stable(rst_lines) && $stable(quad_clock_en))
    else $error("line changed without a write");
  AST_ANY_FOLLOWS: assert property (
    periph_rst_any == |rst_lines)
    else $error("any-reset flag wrong");
  AST_RESET_ZERO: assert property ($rose(rst_n) |->
    rst_lines == 22'h0 && !periph_rst_any)
    else $error("reset lines not zero after reset");
  AST_QUAD_INIT: assert property ($rose(rst_n) |->
    quad_clock_en == 4'hF)
    else $error("quad clock enables not one after reset");
  // Link answer is a single pulse one cycle after the request
  AST_ACK_PULSE: assert property (link_req && !link_ack |=>
    link_ack ##1 !link_ack)
    else $error("link ack not a one-cycle pulse");
endmodule

// ### peripheral_reset_clock_gate_tb.sv
// Self-checking bench: both ends joined by the link, driven over Wishbone.
// Assumes the first pair mounts every unit; a second pair lacks some.
`timescale 1ns/100ps
module peripheral_reset_clock_gate_tb
  import prcg_pkg::*;
;
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i, converter_rst, quad_clock_en;
  logic [31:0] wb_dat_i, wb_dat_o, exp0, exp1;
  logic ext_bus_logic_rst, dma_rst, periph_rst_any;
  logic [15:0] serial_rst;
  logic ext_bus_b, dma_b;
  logic [3:0] converter_b, quad_b;
  logic [15:0] serial_b;
  int failures, compares;

  prcg_if prcg_if_inst();
  prcg_host prcg_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(prcg_if_inst));
  prcg_dev prcg_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(prcg_if_inst), .ext_bus_logic_rst(ext_bus_logic_rst),
    .dma_rst(dma_rst), .converter_rst(converter_rst),
    .serial_rst(serial_rst), .quad_clock_en(quad_clock_en),
    .periph_rst_any(periph_rst_any));
  prcg_checker prcg_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link_req(prcg_if_inst.link_req), .link_we(prcg_if_inst.link_we),
    .link_idx(prcg_if_inst.link_idx),
    .link_wdata(prcg_if_inst.link_wdata),
    .link_ack(prcg_if_inst.link_ack),
    .ext_bus_logic_rst(ext_bus_logic_rst), .dma_rst(dma_rst),
    .converter_rst(converter_rst), .serial_rst(serial_rst),
    .quad_clock_en(quad_clock_en), .periph_rst_any(periph_rst_any));
  // Second pair with some units absent; its bus answer is not used
  prcg_if prcg_if_b_inst();
  prcg_host #(.EXT_BUS_PRESENT(1'h0), .CONVERTER_PRESENT(4'h5),
    .SERIAL_PRESENT(16'h00FF), .QUAD_PRESENT(4'h3)) prcg_host_b_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
    .link(prcg_if_b_inst));
  prcg_dev prcg_dev_b_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(prcg_if_b_inst), .ext_bus_logic_rst(ext_bus_b),
    .dma_rst(dma_b), .converter_rst(converter_b), .serial_rst(serial_b),
    .quad_clock_en(quad_b), .periph_rst_any());

  task automatic summarize();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] got);
    compares++;
    if (got !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask

  // One classic cycle; held until ack, bounded wait ends the run
  task automatic wb(input logic we, input logic [3:0] a,
    input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'h3, we, a, s, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (wb_ack_o !== 1'h1) begin
      failures++;
      summarize();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hF);
    logic [31:0] q;
    wb(1'h1, a, s, d, q);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 4'hF, 32'h0000_0000, q);
    check("register read", e, q);
  endtask

  // Expected lines worked out from the two register images
  task automatic lines(input logic [31:0] r0, input logic [31:0] r1);
    check("reset lines", {10'h000, r0[26], r0[24], r0[19:0]},
      {10'h000, ext_bus_logic_rst, dma_rst, converter_rst, serial_rst});
    check("clock enables", {28'h0, r1[19:16]}, {28'h0, quad_clock_en});
    check("any reset", {31'h0, |{r0[26], r0[24], r0[19:0]}},
      {31'h0, periph_rst_any});
  endtask

  // Second pair: bits of absent units must keep their initial value
  task automatic lines_b(input logic [31:0] r0, input logic [3:0] qc);
    check("sparse reset lines", {10'h000, r0[26], r0[24], r0[19:0]},
      {10'h000, ext_bus_b, dma_b, converter_b, serial_b});
    check("sparse clock enables", {28'h0, qc}, {28'h0, quad_b});
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    lines(32'h0000_0000, 32'h000F_0000);
    rchk(4'h0, 32'h0000_0000);
    rchk(4'h4, 32'h000F_0000);
    // External bus bring-up: pulse its reset, then release it
    wr(4'h0, 32'h0400_0000);
    lines(32'h0400_0000, 32'h000F_0000);
    wr(4'h0, 32'h0000_0000);
    lines(32'h0000_0000, 32'h000F_0000);
    // Walk a single one through every bit, reserved ones included
    for (int i = 0; i < 32; i++) begin
      exp0 = (32'h1 << i) & 32'h050F_FFFF;
      wr(4'h0, 32'h1 << i);
      rchk(4'h0, exp0);
      lines(exp0, 32'h000F_0000);
    end
    // All resets on; they must stand through unrelated traffic
    wr(4'h0, 32'hFFFF_FFFF);
    wr(4'h8, 32'hFFFF_FFFF);
    rchk(4'h8, 32'h0000_0000);
    repeat (10) @(posedge clk_sys);
    lines(32'h050F_FFFF, 32'h000F_0000);
    lines_b(32'h0105_00FF, 4'hF);
    wr(4'h0, 32'h0000_0000);
    lines(32'h0000_0000, 32'h000F_0000);
    // Every clock gate pattern, with reserved bits driven high
    for (int v = 0; v < 16; v++) begin
      exp1 = {12'h000, v[3:0], 16'h0000};
      wr(4'h4, exp1 | 32'hFFF0_FFFF);
      rchk(4'h4, exp1);
      lines(32'h0000_0000, exp1);
    end
    // Unselected byte lanes reuse the last word sent on the link
    wr(4'h0, 32'h0001_00FF);
    wr(4'h0, 32'h0000_AA00, 4'h2);
    rchk(4'h0, 32'h0001_AAFF);
    lines(32'h0001_AAFF, 32'h000F_0000);
    // Mid-run reset must bring every line back to its initial level
    wr(4'h0, 32'h0500_A5A5);
    wr(4'h4, 32'h0000_0000);
    lines(32'h0500_A5A5, 32'h0000_0000);
    lines_b(32'h0100_00A5, 4'hC);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    lines(32'h0000_0000, 32'h000F_0000);
    lines_b(32'h0000_0000, 4'hF);
    rchk(4'h0, 32'h0000_0000);
    rchk(4'h4, 32'h000F_0000);
    summarize();
  end
endmodule
